// [logic/timer_c_pkg.sv]
/*
  Shared constants of the eight-bit reload / watchdog / PWM timer:
  register indices, field positions, reset values and the prescaler taps.
  Assumes an APB slave that places each register in one aligned 32-bit word.
*/
package timer_c_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices: byte address is four times the index
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS = 10'h002;
  localparam logic [IDX_W-1:0] IDX_PORT_SEL = 10'h004;
  localparam logic [IDX_W-1:0] IDX_MODE = 10'h00d;
  localparam logic [IDX_W-1:0] IDX_COUNT_LO = 10'h00e;
  localparam logic [IDX_W-1:0] IDX_COUNT_HI = 10'h00f;
  localparam logic [IDX_W-1:0] IDX_WDOG = 10'h020;
  localparam logic [IDX_W-1:0] IDX_INT_STATUS = 10'h030;
  localparam logic [IDX_W-1:0] IDX_INT_MASK = 10'h031;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int IRQF_TIMER_BIT = 2;
  localparam int WDOG_EN_BIT = 1;
  localparam int PORT_TOUT_BIT = 3;
  localparam int MODE_RELOAD_BIT = 3;
  localparam int ST_OVF_BIT = 0;
  localparam int ST_WDOG_BIT = 1;
  localparam int DIV_SEL_W = 3;
  localparam int NIB_W = 4;
  localparam int CNT_W = 8;
  localparam int EV_W = 2;

  ////////////////////////////////////////////////////////////////////////////
  // values
  localparam logic [CNT_W-1:0] COUNT_MAX = 8'hff;
  localparam logic [CNT_W-1:0] COUNT_ZERO = 8'h00;
  localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  localparam int MODE_DELAY_INSTR = 2;
  localparam int PRESC_W = 11;

  // holdoff of a mode-register write
  typedef enum logic {
    MODE_IDLE = 1'b0,
    MODE_WAIT = 1'b1
  } mode_st_e;

  // prescaler tap per division code: 1,4,8,32,128,512,1024,2048
  function automatic logic [PRESC_W-1:0] tap_mask(input logic [DIV_SEL_W-1:0] sel);
    unique case (sel)
      3'h0: tap_mask = 11'h000;
      3'h1: tap_mask = 11'h003;
      3'h2: tap_mask = 11'h007;
      3'h3: tap_mask = 11'h01f;
      3'h4: tap_mask = 11'h07f;
      3'h5: tap_mask = 11'h1ff;
      3'h6: tap_mask = 11'h3ff;
      3'h7: tap_mask = 11'h7ff;
    endcase
  endfunction : tap_mask

endpackage : timer_c_pkg

// [logic/tick_if.sv]
/*
  Carrier between the timer core and its prescaler: division select out,
  count tick back. Assumes both ends share sys_clk.
*/
interface tick_if;
  logic [timer_c_pkg::DIV_SEL_W-1:0] div_sel;
  logic tick;
  modport presc (input div_sel, output tick);
  modport core (output div_sel, input tick);
endinterface : tick_if

// [logic/clock_prescaler.sv]
/*
  Free-running prescaler that issues a one-cycle count tick at the selected
  division ratio. Assumes div_sel is stable between mode changes.
*/
module clock_prescaler (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // to the timer core
  tick_if.presc tk
);

  logic [timer_c_pkg::PRESC_W-1:0] pre_q, pre_d;
  logic tick_q, tick_d;

  ////////////////////////////////////////////////////////////////////////////
  // tick when every bit under the tap is one
  always_comb begin
    pre_d = pre_q + 11'h001;
    tick_d = (pre_q & timer_c_pkg::tap_mask(tk.div_sel)) == timer_c_pkg::tap_mask(tk.div_sel);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 11'h000;
      tick_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      tick_q <= tick_d;
    end
  end

  assign tk.tick = tick_q;

endmodule : clock_prescaler

// [logic/pwm_shaper.sv]
/*
  Variable-duty pulse generator. Takes the live count, the preset and the
  overflow strobe from the timer core. Free-running: high while the count is
  at or above the preset. Reload: level toggles on every overflow.
*/
module pwm_shaper (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // from the timer core
  input wire logic [timer_c_pkg::CNT_W-1:0] count,
  input wire logic [timer_c_pkg::CNT_W-1:0] preset,
  input wire logic reload_mode,
  input wire logic overflow,
  // waveform
  output logic level
);

  logic [timer_c_pkg::CNT_W-1:0] duty_q, duty_d;
  logic tog_q, tog_d;
  logic level_q, level_d;

  ////////////////////////////////////////////////////////////////////////////
  // the duty point is taken only at overflow, so a fresh preset is not
  // honoured until the next overflow; keeps each period whole
  always_comb begin
    duty_d = overflow ? preset : duty_q; // RQ7
    tog_d = overflow ? ~tog_q : tog_q;
    level_d = reload_mode ? tog_q : (count >= duty_q); // RQ7
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_q <= timer_c_pkg::COUNT_ZERO;
      tog_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      duty_q <= duty_d;
      tog_q <= tog_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;

endmodule : pwm_shaper

// [logic/timer_c_reload_watchdog_pwm.sv]
/*
  Eight-bit up-counting timer with free-running and reload modes, watchdog
  reset request and PWM output on a shared port pin, reached over APB.
  Assumes sys_clk at 250 MHz, rst_n asynchronous active low, and that the
  MCU-level reset is generated outside from mcu_reset_req.
*/
// Behaviour
// [RQ1] load preset, then count up per tick
// [RQ2] overflow at all ones: reload or restart zero
// [RQ3] overflow sets timer flag bit two
// [RQ4] flag stays until software clear or reset
// [RQ5] watchdog enabled: overflow requests MCU reset
// [RQ6] port select routes timer output, low at reset
// [RQ7] PWM duty and period from mode, preset
// [RQ8] four-bit mode register, cleared at reset
// [RQ9] mode write effective two instruction cycles later
// [RQ10] software presets only after mode is effective
// [RQ11] low nibble first; high write loads counter
// [RQ12] high read latches low nibble for coherence
// [RQ13] PWM invalid until overflow after preset update
// [RQ14] preset low nibble clears at reset
// [RQ15] mode encodings and PWM edges are fixed
module timer_c_reload_watchdog_pwm #(
  parameter int INSTR_CLKS = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // shared port pin
  output logic shared_timer_out_pin_o,
  output logic shared_timer_out_pin_oe,
  output logic timer_pulse_out,
  // system
  output logic mcu_reset_req,
  output logic irq
);

  localparam int MODE_DELAY_CYC = timer_c_pkg::MODE_DELAY_INSTR * INSTR_CLKS;
  localparam int HOLD_W = $clog2(MODE_DELAY_CYC + 1);
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(MODE_DELAY_CYC - 1);
  localparam logic [HOLD_W-1:0] HOLD_ZERO = '0;

  tick_if tk ();

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [timer_c_pkg::NIB_W-1:0] lo_cand_q, lo_cand_d;
  logic [timer_c_pkg::NIB_W-1:0] lo_latch_q, lo_latch_d;
  logic [timer_c_pkg::NIB_W-1:0] mode_q, mode_d;
  logic [timer_c_pkg::NIB_W-1:0] mode_pend_q, mode_pend_d;
  timer_c_pkg::mode_st_e mst_q, mst_d;
  logic [HOLD_W-1:0] hold_q, hold_d;
  logic [timer_c_pkg::NIB_W-1:0] port_sel_q, port_sel_d;
  logic [timer_c_pkg::NIB_W-1:0] pre_lo_q, pre_lo_d;
  logic [timer_c_pkg::NIB_W-1:0] pre_hi_q, pre_hi_d;
  logic [timer_c_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic ovf_q, ovf_d;
  logic tflag_q, tflag_d;
  logic wdog_q, wdog_d;
  logic [timer_c_pkg::EV_W-1:0] status_q, status_d;
  logic [timer_c_pkg::EV_W-1:0] mask_q, mask_d;
  logic irq_q, irq_d;
  logic rst_req_q, rst_req_d;
  logic pin_q, pin_d;
  logic pin_oe_q, pin_oe_d;
  logic tout_q, tout_d;
  logic pwm_level;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic setup, access_done, wr, rd, mapped;
  logic [timer_c_pkg::IDX_W-1:0] idx;
  logic [timer_c_pkg::CNT_W-1:0] preset;
  logic [timer_c_pkg::EV_W-1:0] events;

  function automatic logic is_mapped(input logic [timer_c_pkg::IDX_W-1:0] i);
    is_mapped = (i == timer_c_pkg::IDX_IRQ_FLAGS) || (i == timer_c_pkg::IDX_PORT_SEL)
             || (i == timer_c_pkg::IDX_MODE) || (i == timer_c_pkg::IDX_COUNT_LO)
             || (i == timer_c_pkg::IDX_COUNT_HI) || (i == timer_c_pkg::IDX_WDOG)
             || (i == timer_c_pkg::IDX_INT_STATUS) || (i == timer_c_pkg::IDX_INT_MASK);
  endfunction : is_mapped

  // writes and read side effects happen only at the edge that ends the access
  assign idx = paddr[11:2];
  assign mapped = is_mapped(idx);
  assign setup = psel && !penable;
  assign access_done = psel && penable && pready_q;
  assign wr = access_done && pwrite && mapped;
  assign rd = access_done && !pwrite && mapped;
  assign preset = {pre_hi_q, pre_lo_q};

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: read data is formed in the setup cycle so that it comes from
  // a flip-flop; pready rises in the first access cycle, so no transfer has a wait state
  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    pready_d = setup;
    lo_cand_d = lo_cand_q;
    if (setup) begin
      pslverr_d = !mapped;
      prdata_d = timer_c_pkg::RDATA_ZERO;
      lo_cand_d = cnt_q[3:0];
      if (!pwrite) begin
        unique case (idx)
          timer_c_pkg::IDX_IRQ_FLAGS: prdata_d[timer_c_pkg::IRQF_TIMER_BIT] = tflag_q;
          timer_c_pkg::IDX_COUNT_HI: prdata_d[3:0] = cnt_q[7:4]; // RQ12
          timer_c_pkg::IDX_COUNT_LO: prdata_d[3:0] = lo_latch_q; // RQ12
          timer_c_pkg::IDX_WDOG: prdata_d[timer_c_pkg::WDOG_EN_BIT] = wdog_q;
          timer_c_pkg::IDX_INT_STATUS: prdata_d[1:0] = status_q;
          timer_c_pkg::IDX_INT_MASK: prdata_d[1:0] = mask_q;
          default: prdata_d = timer_c_pkg::RDATA_ZERO; // write-only and unmapped
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= timer_c_pkg::RDATA_ZERO;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      lo_cand_q <= timer_c_pkg::NIB_RESET;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      lo_cand_q <= lo_cand_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode register: a write is parked and applied after the holdoff; a write
  // landing inside the holdoff replaces the parked value and restarts it
  always_comb begin
    mode_d = mode_q;
    mode_pend_d = mode_pend_q;
    mst_d = mst_q;
    hold_d = hold_q;
    if (wr && idx == timer_c_pkg::IDX_MODE) begin
      mode_pend_d = pwdata[3:0]; // RQ8
      mst_d = timer_c_pkg::MODE_WAIT;
      hold_d = HOLD_LOAD; // RQ9
    end else begin
      unique case (mst_q)
        timer_c_pkg::MODE_IDLE: hold_d = HOLD_ZERO;
        timer_c_pkg::MODE_WAIT: begin
          if (hold_q == HOLD_ZERO) begin
            mode_d = mode_pend_q; // RQ9
            mst_d = timer_c_pkg::MODE_IDLE;
          end else begin
            hold_d = hold_q - 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= timer_c_pkg::NIB_RESET; // RQ8
      mode_pend_q <= timer_c_pkg::NIB_RESET;
      mst_q <= timer_c_pkg::MODE_IDLE;
      hold_q <= HOLD_ZERO;
    end else begin
      mode_q <= mode_d;
      mode_pend_q <= mode_pend_d;
      mst_q <= mst_d;
      hold_q <= hold_d;
    end
  end

  // division code drives the prescaler tap
  assign tk.div_sel = mode_q[timer_c_pkg::DIV_SEL_W-1:0]; // RQ15

  clock_prescaler u_presc (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tk(tk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // preset, counter and read latch
  always_comb begin
    pre_lo_d = pre_lo_q;
    pre_hi_d = pre_hi_q;
    cnt_d = cnt_q;
    ovf_d = 1'b0;
    lo_latch_d = lo_latch_q;
    if (tk.tick) begin
      if (cnt_q == timer_c_pkg::COUNT_MAX) begin
        ovf_d = 1'b1; // RQ2
        cnt_d = mode_q[timer_c_pkg::MODE_RELOAD_BIT] ? preset : timer_c_pkg::COUNT_ZERO; // RQ2
      end else begin
        cnt_d = cnt_q + 8'h01; // RQ1
      end
    end
    // a software load wins over a tick in the same cycle
    if (wr && idx == timer_c_pkg::IDX_COUNT_LO) begin
      pre_lo_d = pwdata[3:0]; // RQ11
    end
    if (wr && idx == timer_c_pkg::IDX_COUNT_HI) begin
      pre_hi_d = pwdata[3:0];
      cnt_d = {pwdata[3:0], pre_lo_q}; // RQ1 RQ11
    end
    if (rd && idx == timer_c_pkg::IDX_COUNT_HI) begin
      lo_latch_d = lo_cand_q; // RQ12
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_lo_q <= timer_c_pkg::NIB_RESET; // RQ14
      pre_hi_q <= timer_c_pkg::NIB_RESET;
      cnt_q <= timer_c_pkg::COUNT_ZERO;
      ovf_q <= 1'b0;
      lo_latch_q <= timer_c_pkg::NIB_RESET;
    end else begin
      pre_lo_q <= pre_lo_d;
      pre_hi_q <= pre_hi_d;
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
      lo_latch_q <= lo_latch_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags, watchdog and interrupt; a hardware set always beats a clear
  assign events = {ovf_q && wdog_q, ovf_q};

  always_comb begin
    tflag_d = tflag_q;
    wdog_d = wdog_q;
    mask_d = mask_q;
    status_d = status_q;
    port_sel_d = port_sel_q;
    if (wr && idx == timer_c_pkg::IDX_IRQ_FLAGS) begin
      tflag_d = pwdata[timer_c_pkg::IRQF_TIMER_BIT]; // RQ4
    end
    if (wr && idx == timer_c_pkg::IDX_WDOG) begin
      wdog_d = pwdata[timer_c_pkg::WDOG_EN_BIT];
    end
    if (wr && idx == timer_c_pkg::IDX_INT_MASK) begin
      mask_d = pwdata[1:0];
    end
    if (wr && idx == timer_c_pkg::IDX_PORT_SEL) begin
      port_sel_d = pwdata[3:0];
    end
    // clear on read only the bits that the read actually returned
    if (rd && idx == timer_c_pkg::IDX_INT_STATUS) begin
      status_d = status_q & ~prdata_q[1:0];
    end
    status_d = status_d | events;
    if (ovf_q) begin
      tflag_d = 1'b1; // RQ3
    end
    irq_d = |(status_d & mask_d);
    rst_req_d = ovf_q && wdog_q; // RQ5
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tflag_q <= 1'b0; // RQ4
      wdog_q <= 1'b0;
      mask_q <= '0;
      status_q <= '0;
      port_sel_q <= timer_c_pkg::NIB_RESET;
      irq_q <= 1'b0;
      rst_req_q <= 1'b0;
    end else begin
      tflag_q <= tflag_d;
      wdog_q <= wdog_d;
      mask_q <= mask_d;
      status_q <= status_d;
      port_sel_q <= port_sel_d;
      irq_q <= irq_d;
      rst_req_q <= rst_req_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm and the shared pin; the level only tracks the preset from the next
  // overflow on, so early periods after a preset update are not trustworthy
  pwm_shaper u_pwm (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .count(cnt_q),
    .preset(preset),
    .reload_mode(mode_q[timer_c_pkg::MODE_RELOAD_BIT]),
    .overflow(ovf_q),
    .level(pwm_level)
  );

  always_comb begin
    tout_d = pwm_level; // RQ7
    pin_oe_d = port_sel_q[timer_c_pkg::PORT_TOUT_BIT]; // RQ6
    pin_d = port_sel_q[timer_c_pkg::PORT_TOUT_BIT] && pwm_level; // RQ6
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tout_q <= 1'b0; // RQ6
      pin_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      tout_q <= tout_d;
      pin_q <= pin_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign shared_timer_out_pin_o = pin_q;
  assign shared_timer_out_pin_oe = pin_oe_q;
  assign timer_pulse_out = tout_q;
  assign mcu_reset_req = rst_req_q;
  assign irq = irq_q;

endmodule : timer_c_reload_watchdog_pwm

// [verif/timer_c_sva.sv]
/*
  Port checker of the eight-bit timer: apb answer timing, error decode,
  watchdog pulse, shared pin gating and interrupt level.
  Assumes a bind onto the timer top, one clock, rst_n active low.
*/
module timer_c_sva #(
  parameter int INSTR_CLKS = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pin and system
  input wire logic shared_timer_out_pin_o,
  input wire logic shared_timer_out_pin_oe,
  input wire logic timer_pulse_out,
  input wire logic mcu_reset_req,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic mapped;

  ////////////////////////////////////////////////////////////////////////////
  // index decode of every mapped word
  assign mapped = paddr[11:2] inside {timer_c_pkg::IDX_IRQ_FLAGS, timer_c_pkg::IDX_PORT_SEL,
    timer_c_pkg::IDX_MODE, timer_c_pkg::IDX_COUNT_LO, timer_c_pkg::IDX_COUNT_HI,
    timer_c_pkg::IDX_WDOG, timer_c_pkg::IDX_INT_STATUS, timer_c_pkg::IDX_INT_MASK};

  ////////////////////////////////////////////////////////////////////////////
  property p_ready_next; psel && !penable |=> pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("pready late after setup");
  property p_ready_one; pready |=> !pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready held two cycles");
  property p_err_unmapped; pready && !mapped |-> pslverr && prdata == 32'h0; endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
  property p_err_mapped; pready && mapped |-> !pslverr; endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  property p_wdog_pulse; $rose(mcu_reset_req) |=> !mcu_reset_req; endproperty
  a_wdog_pulse: assert property (p_wdog_pulse) else $error("reset request too long");
  property p_pin_gated; !shared_timer_out_pin_oe |-> !shared_timer_out_pin_o; endproperty
  a_pin_gated: assert property (p_pin_gated) else $error("pin driven while port deselected");
  property p_pin_follow; shared_timer_out_pin_oe |-> shared_timer_out_pin_o == timer_pulse_out; endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("pin differs from pulse");
  // irq only drops after a register access cleared status or mask
  property p_irq_fall; $fell(irq) |-> $past(pready) || $past(pready, 2) || $past(pready, 3); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
endmodule : timer_c_sva

// [verif/timer_c_reload_watchdog_pwm_tb.sv]
/*
  Self-checking bench of the eight-bit timer: apb master tasks, scenario
  sequence and expected values from the register and counting rules.
  Assumes the design package compiled first; INSTR_CLKS set to 1.
*/
module timer_c_reload_watchdog_pwm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, pin_o, pin_oe, pulse, wdog_req, irq;
  logic [7:0] cnt;
  int num_errors, n_compared, cyc, pulses, v, d;

  timer_c_reload_watchdog_pwm #(.INSTR_CLKS(1)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shared_timer_out_pin_o(pin_o), .shared_timer_out_pin_oe(pin_oe), .timer_pulse_out(pulse),
    .mcu_reset_req(wdog_req), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // clock, hang limit well above the ~1000 cycles needed, reset pulses
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (wdog_req === 1'b1) pulses++;
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////////
  // one apb transfer; an idle cycle precedes each setup
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    check("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    check("rdata", exp, rd);
  endtask : rchk

  // low nibble first, the high write loads the counter
  task automatic preset(input logic [7:0] p);
    xfer(1'b1, timer_c_pkg::IDX_COUNT_LO, {28'h0, p[3:0]});
    xfer(1'b1, timer_c_pkg::IDX_COUNT_HI, {28'h0, p[7:4]});
  endtask : preset

  // high nibble first latches the low one; d is the drift from v
  task automatic rcount();
    xfer(1'b0, timer_c_pkg::IDX_COUNT_HI, 32'h0);
    cnt[7:4] = rd[3:0];
    xfer(1'b0, timer_c_pkg::IDX_COUNT_LO, 32'h0);
    cnt[3:0] = rd[3:0];
    d = int'(cnt) - v;
  endtask : rcount

  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      xfer(1'b0, timer_c_pkg::IDX_IRQ_FLAGS, 32'h0);
      n++;
    end while (rd[2] !== 1'b1 && n < 300);
    check("flag", 32'h4, rd);
  endtask : wait_flag

  ////////////////////////////////////////////////////////////////////////////
  // scenario sequence
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    v = $urandom(32'h8f5e);
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset state, write-only read, unmapped word
    rchk(timer_c_pkg::IDX_IRQ_FLAGS, 32'h0);
    rchk(timer_c_pkg::IDX_MODE, 32'h0);
    xfer(1'b0, 10'h3ff, 32'h0);
    check("pslverr", 32'h1, {31'h0, err});
    check("pin", 32'h0, {30'h0, pin_o, pin_oe});
    // low preset nibble is zero from reset, so a lone high write loads 0x50
    v = 32'h50;
    xfer(1'b1, timer_c_pkg::IDX_COUNT_HI, 32'h5);
    rcount();
    check("lo_reset", 32'h1, 32'(d inside {[0:2]}));
    // slow prescaler so the count barely drifts while read back
    xfer(1'b1, timer_c_pkg::IDX_MODE, 32'h7);
    for (int i = 0; i < 4; i++) begin
      v = $urandom_range(253, 0);
      preset(8'(v));
      rcount();
      check("load", 32'h1, 32'(d inside {[0:2]}));
      xfer(1'b1, timer_c_pkg::IDX_COUNT_LO, 32'(~v & 15));
      rcount();
      check("lo_only", 32'h1, 32'(d inside {[0:2]}));
    end
    // free-running wrap to zero, flag stays until written
    xfer(1'b1, timer_c_pkg::IDX_MODE, 32'h0);
    preset(8'hf0);
    wait_flag();
    rchk(timer_c_pkg::IDX_COUNT_HI, 32'h0);
    check("irq", 32'h0, {31'h0, irq});
    rchk(timer_c_pkg::IDX_INT_STATUS, 32'h1);
    rchk(timer_c_pkg::IDX_IRQ_FLAGS, 32'h4);
    xfer(1'b1, timer_c_pkg::IDX_IRQ_FLAGS, 32'h0);
    rchk(timer_c_pkg::IDX_IRQ_FLAGS, 32'h0);
    // unmasked interrupt, cleared by the status read
    xfer(1'b1, timer_c_pkg::IDX_INT_MASK, 32'h1);
    preset(8'hf0);
    repeat (40) @(posedge sys_clk);
    check("irq", 32'h1, {31'h0, irq});
    rchk(timer_c_pkg::IDX_INT_STATUS, 32'h1);
    repeat (3) @(posedge sys_clk);
    check("irq", 32'h0, {31'h0, irq});
    xfer(1'b1, timer_c_pkg::IDX_INT_MASK, 32'h0);
    // reload keeps the count at or above the preset
    xfer(1'b1, timer_c_pkg::IDX_MODE, 32'h8);
    preset(8'hf0);
    for (int i = 0; i < 6; i++) begin
      repeat (5) @(posedge sys_clk);
      rchk(timer_c_pkg::IDX_COUNT_HI, 32'hf);
    end
    // reload pulse toggles per overflow: 16 counts from 0xf0, so half of 64
    d = 0;
    repeat (64) begin
      @(posedge sys_clk);
      d += int'(pulse === 1'b1);
    end
    check("rl_duty", 32'h20, 32'(d));
    // watchdog requests reset on overflow only while enabled
    d = pulses;
    xfer(1'b1, timer_c_pkg::IDX_WDOG, 32'h2);
    repeat (40) @(posedge sys_clk);
    xfer(1'b1, timer_c_pkg::IDX_WDOG, 32'h0);
    check("wdog", 32'h1, 32'(pulses - d >= 2));
    xfer(1'b0, timer_c_pkg::IDX_INT_STATUS, 32'h0);
    check("wdog_st", 32'h3, rd & 32'h3);
    d = pulses;
    repeat (40) @(posedge sys_clk);
    check("wdog_off", 32'(d), 32'(pulses));
    // free-running pwm on the pin: high for 256 - N of 256 counts
    xfer(1'b1, timer_c_pkg::IDX_MODE, 32'h0);
    xfer(1'b1, timer_c_pkg::IDX_PORT_SEL, 32'h8);
    v = $urandom_range(192, 64);
    preset(8'(v));
    repeat (300) @(posedge sys_clk);
    check("oe", 32'h1, {31'h0, pin_oe});
    d = 0;
    repeat (256) begin
      @(posedge sys_clk);
      d += int'(pin_o === 1'b1);
    end
    check("duty", 32'(256 - v), 32'(d));
    summarize();
  end
endmodule : timer_c_reload_watchdog_pwm_tb

bind timer_c_reload_watchdog_pwm timer_c_sva #(.INSTR_CLKS(INSTR_CLKS)) u_sva (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .shared_timer_out_pin_o(shared_timer_out_pin_o), .shared_timer_out_pin_oe(shared_timer_out_pin_oe),
  .timer_pulse_out(timer_pulse_out), .mcu_reset_req(mcu_reset_req), .irq(irq));
